// ===== rtl/can_moh_pkg.sv
/*
  holds the constants and types of the message object handler: register
  offsets, field positions, reset values, measurement codes and the state.
  assumes a 32-bit apb slave with 12-bit byte addresses.
*/
package can_moh_pkg;

  // ************************************************
  // sizes
  // ************************************************
  localparam int NOBJ = 8;
  localparam int IDX_W = 3;
  localparam int CNT_W = 16;
  localparam int ID_W = 11;

  // ************************************************
  // register offsets (byte addresses)
  // ************************************************
  localparam logic [11:0] A_NODE_CTRL = 12'h000;
  localparam logic [11:0] A_NODE_STAT = 12'h004;
  localparam logic [11:0] A_FRAME_CNT = 12'h008;
  localparam logic [11:0] A_FIFO_CTRL = 12'h00c;
  localparam logic [11:0] A_FIFO_SEG = 12'h010;
  localparam logic [11:0] A_OBJ_CTRL = 12'h040;
  localparam logic [11:0] A_OBJ_DATA = 12'h080;

  // ************************************************
  // field positions
  // ************************************************
  localparam int F_INIT = 0;
  localparam int F_FCMODE = 1;
  localparam int F_FCSEL = 3;
  localparam int F_LOE = 0;
  localparam int F_BUSY = 1;
  localparam int F_OVIE = 0;
  localparam int F_CUR = 8;
  localparam int F_SEL = 16;
  localparam int F_BOT = 0;
  localparam int F_TOP = 8;
  localparam int F_VALID = 0;
  localparam int F_RECEIVE_ENABLE_BIT = 1;
  localparam int F_TXEN = 2;
  localparam int F_TXRQ = 3;
  localparam int F_SDT = 4;
  localparam int F_FRREN = 5;
  localparam int F_NEW_DATA_FLAG = 6;
  localparam int F_MESSAGE_LOST_FLAG = 7;
  localparam int F_RECEIVE_PENDING_FLAG = 8;
  localparam int F_RECEIVE_UPDATING_FLAG = 9;
  localparam int F_ID = 16;

  // ************************************************
  // reset values and codes
  // ************************************************
  localparam logic RST_INIT = 1'b1;
  localparam logic [1:0] FCMODE_TIMING = 2'b10;
  localparam logic [2:0] FCSEL_REC_AFTER_DOM = 3'b001;
  localparam logic [2:0] FCSEL_TX_DOM_LOOP = 3'b010;
  localparam logic [2:0] FCSEL_TX_REC_LOOP = 3'b011;
  localparam logic [2:0] FCSEL_SYNC_TO_SP = 3'b100;

  // ************************************************
  // types
  // ************************************************
  typedef enum logic [0:0] {RX_IDLE, RX_UPDATE} rx_phase_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [31:0] data;
  } tx_frame_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic [31:0] data;
    logic valid, rx_en, tx_en, txrq, single_transfer_mode, frren, new_data_flag, message_lost_flag, receive_pending_flag, receive_updating_flag;
  } obj_t;

  typedef struct packed {
    obj_t [NOBJ-1:0] obj;
    logic node_init;
    logic [1:0] fc_mode;
    logic [2:0] fc_sel;
    logic [CNT_W-1:0] fc_value;
    logic loe;
    logic ovie;
    logic [IDX_W-1:0] cur, sel, bot, top;
    logic tx_busy, tx_hold;
    logic [IDX_W-1:0] tx_idx;
    tx_frame_t tx_frame;
    rx_phase_t rx_phase;
    logic [IDX_W-1:0] rx_idx;
    logic [31:0] rx_data;
    logic rx_remote;
    logic prev_rx, prev_tx;
    logic [CNT_W-1:0] cnt_dom, cnt_txd, cnt_txr, cnt_sp;
    logic [31:0] prdata;
    logic pslverr;
    logic ovf, rx_irq;
  } state_t;

endpackage

// ===== rtl/can_msg_obj_handler.sv
/*
  message object handler of one can node: object table, receive storage,
  transmit selection with resend, tx fifo pointer and bit timing measurement.
  assumes the protocol engine gives synchronous one-cycle event pulses and
  the bus levels, and that software reaches the registers over apb.
*/
// Chosen here: the APB register port and the placing of the registers.
// Contract
// (R1) fifo pointer hits limit with enable: overflow pulse
// (R2) filtering priority order; destroyed frame resent first
// (R3) list error: set flag, frame not stored
// (R4) list error reruns tx filtering, ongoing tx kept
// (R5) software keeps first list element while node active
// (R6) single transfer clears valid after reception
// (R7) failed answer with valid cleared: no retry
// (R8) software sets foreign remote enable against answers
// (R9) frame counter mode 10 measures bit timing
// (R10) select 001: recessive edge since dominant edge
// (R11) select 010: dominant tx to rx loop time
// (R12) select 011: recessive tx to rx loop time
// (R13) select 100: sync edge since sample point
// (R14) clearing one valid bit touches no other object
// (R15) storage sets flags and raises receive pulse
// (R16) copy to tx buffer clears new data
// (R17) software disables objects by enable bits
// (R18) software keeps fifo base outside circular list
// (R19) receive updating flag brackets the storage
// (R20) withdrawn request reruns transmit filtering
module can_msg_obj_handler (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RX_FRAME_I,
  input wire logic RX_REMOTE_I,
  input wire logic RX_LIST_ERR_I,
  input wire logic [can_moh_pkg::ID_W-1:0] RX_ID_I,
  input wire logic [31:0] RX_DATA_I,
  input wire logic TX_ACTIVE_I,
  input wire logic TX_DONE_I,
  input wire logic TX_ERR_I,
  input wire logic CAN_RX_I,
  input wire logic CAN_TX_I,
  input wire logic SAMPLE_POINT_I,
  input wire logic SYNC_EDGE_I,
  output logic TX_VALID_O,
  output can_moh_pkg::tx_frame_t TX_FRAME_O,
  output logic RX_IRQ_O,
  output logic TX_OVERFLOW_O
);

  // ************************************************
  // state and helpers
  // ************************************************
  can_moh_pkg::state_t s;
  can_moh_pkg::state_t next_s;
  logic rx_fall, rx_rise, tx_fall, tx_rise, tx_withdrawn;
  logic [can_moh_pkg::CNT_W-1:0] since_dom, since_txd, since_txr, since_sp;
  logic [3:0] widx;
  logic obj_ok;

  function automatic logic [can_moh_pkg::CNT_W-1:0] sat_inc(
    input logic [can_moh_pkg::CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // edges on the bus levels, dominant is low
  assign rx_fall = s.prev_rx & ~CAN_RX_I;
  assign rx_rise = ~s.prev_rx & CAN_RX_I;
  assign tx_fall = s.prev_tx & ~CAN_TX_I;
  assign tx_rise = ~s.prev_tx & CAN_TX_I;
  // cycles since each reference point, zero when it is in this cycle
  assign since_dom = rx_fall ? '0 : sat_inc(s.cnt_dom);
  assign since_txd = tx_fall ? '0 : sat_inc(s.cnt_txd);
  assign since_txr = tx_rise ? '0 : sat_inc(s.cnt_txr);
  assign since_sp = SAMPLE_POINT_I ? '0 : sat_inc(s.cnt_sp);
  // object register word index
  assign widx = PADDR_I[5:2];
  assign obj_ok = (widx < 4'(can_moh_pkg::NOBJ)) && (PADDR_I[1:0] == 2'h0);
  assign tx_withdrawn = s.tx_busy & ~(s.obj[s.tx_idx].valid & s.obj[s.tx_idx].tx_en
    & s.obj[s.tx_idx].txrq);

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    logic found;
    logic [can_moh_pkg::IDX_W-1:0] i;
    logic [can_moh_pkg::IDX_W-1:0] nc;
    found = 1'b0;
    i = '0;
    nc = '0;
    next_s = s;
    next_s.ovf = 1'b0;
    next_s.rx_irq = 1'b0;
    next_s.tx_hold = 1'b0;
    next_s.prev_rx = CAN_RX_I;
    next_s.prev_tx = CAN_TX_I;
    next_s.cnt_dom = since_dom;
    next_s.cnt_txd = since_txd;
    next_s.cnt_txr = since_txr;
    next_s.cnt_sp = since_sp;

    // apb setup phase: registered read data and error answer
    if (PSEL_I && !PENABLE_I) begin
      next_s.prdata = '0;
      next_s.pslverr = 1'b0;
      if (PADDR_I[11:6] == can_moh_pkg::A_OBJ_CTRL[11:6] && obj_ok) begin
        i = widx[can_moh_pkg::IDX_W-1:0];
        next_s.prdata = {5'h0, s.obj[i].id, 6'h0, s.obj[i].receive_updating_flag, s.obj[i].receive_pending_flag,
          s.obj[i].message_lost_flag, s.obj[i].new_data_flag, s.obj[i].frren, s.obj[i].single_transfer_mode,
          s.obj[i].txrq, s.obj[i].tx_en, s.obj[i].rx_en, s.obj[i].valid};
      end else if (PADDR_I[11:6] == can_moh_pkg::A_OBJ_DATA[11:6] && obj_ok) begin
        next_s.prdata = s.obj[widx[can_moh_pkg::IDX_W-1:0]].data;
      end else begin
        unique case (PADDR_I)
          can_moh_pkg::A_NODE_CTRL: next_s.prdata = {26'h0, s.fc_sel, s.fc_mode, s.node_init};
          can_moh_pkg::A_NODE_STAT: next_s.prdata = {30'h0, s.tx_busy, s.loe};
          can_moh_pkg::A_FRAME_CNT: next_s.prdata = 32'(s.fc_value);
          can_moh_pkg::A_FIFO_CTRL: next_s.prdata = {8'h0, 5'h0, s.sel, 5'h0, s.cur,
            7'h0, s.ovie};
          can_moh_pkg::A_FIFO_SEG: next_s.prdata = {16'h0, 5'h0, s.top, 5'h0, s.bot};
          default: next_s.pslverr = 1'b1;
        endcase
      end
    end

    // apb access phase: writes land first, hardware events below win
    if (PSEL_I && PENABLE_I && PWRITE_I && !s.pslverr) begin
      i = widx[can_moh_pkg::IDX_W-1:0];
      if (PADDR_I[11:6] == can_moh_pkg::A_OBJ_CTRL[11:6]) begin
        // only the addressed object changes
        next_s.obj[i].valid = PWDATA_I[can_moh_pkg::F_VALID]; // R14
        next_s.obj[i].rx_en = PWDATA_I[can_moh_pkg::F_RECEIVE_ENABLE_BIT];
        next_s.obj[i].tx_en = PWDATA_I[can_moh_pkg::F_TXEN];
        next_s.obj[i].txrq = PWDATA_I[can_moh_pkg::F_TXRQ];
        next_s.obj[i].single_transfer_mode = PWDATA_I[can_moh_pkg::F_SDT];
        next_s.obj[i].frren = PWDATA_I[can_moh_pkg::F_FRREN];
        next_s.obj[i].new_data_flag = PWDATA_I[can_moh_pkg::F_NEW_DATA_FLAG];
        next_s.obj[i].message_lost_flag = PWDATA_I[can_moh_pkg::F_MESSAGE_LOST_FLAG];
        next_s.obj[i].receive_pending_flag = PWDATA_I[can_moh_pkg::F_RECEIVE_PENDING_FLAG];
        next_s.obj[i].id = PWDATA_I[can_moh_pkg::F_ID +: can_moh_pkg::ID_W];
      end else if (PADDR_I[11:6] == can_moh_pkg::A_OBJ_DATA[11:6]) begin
        next_s.obj[i].data = PWDATA_I;
      end else begin
        unique case (PADDR_I)
          can_moh_pkg::A_NODE_CTRL: begin
            next_s.node_init = PWDATA_I[can_moh_pkg::F_INIT];
            next_s.fc_mode = PWDATA_I[can_moh_pkg::F_FCMODE +: 2];
            next_s.fc_sel = PWDATA_I[can_moh_pkg::F_FCSEL +: 3];
          end
          can_moh_pkg::A_NODE_STAT: begin
            if (PWDATA_I[can_moh_pkg::F_LOE]) begin
              next_s.loe = 1'b0;
            end
          end
          can_moh_pkg::A_FIFO_CTRL: begin
            next_s.ovie = PWDATA_I[can_moh_pkg::F_OVIE];
            next_s.cur = PWDATA_I[can_moh_pkg::F_CUR +: can_moh_pkg::IDX_W];
            next_s.sel = PWDATA_I[can_moh_pkg::F_SEL +: can_moh_pkg::IDX_W];
          end
          can_moh_pkg::A_FIFO_SEG: begin
            next_s.bot = PWDATA_I[can_moh_pkg::F_BOT +: can_moh_pkg::IDX_W];
            next_s.top = PWDATA_I[can_moh_pkg::F_TOP +: can_moh_pkg::IDX_W];
          end
          default: next_s.loe = next_s.loe;
        endcase
      end
    end

    // bit timing measurement into the frame counter value
    if (s.fc_mode == can_moh_pkg::FCMODE_TIMING) begin // R9
      unique case (s.fc_sel)
        can_moh_pkg::FCSEL_REC_AFTER_DOM: begin
          if (rx_rise) next_s.fc_value = sat_inc(s.cnt_dom); // R10
        end
        can_moh_pkg::FCSEL_TX_DOM_LOOP: begin
          if (rx_fall && !CAN_TX_I) next_s.fc_value = since_txd; // R11
        end
        can_moh_pkg::FCSEL_TX_REC_LOOP: begin
          if (rx_rise && CAN_TX_I) next_s.fc_value = since_txr; // R12
        end
        can_moh_pkg::FCSEL_SYNC_TO_SP: begin
          if (rx_fall && SYNC_EDGE_I) next_s.fc_value = since_sp; // R13
        end
        default: next_s.fc_value = s.fc_value;
      endcase
    end

    // receive: filtering, or list error that skips it
    if (RX_FRAME_I && !s.node_init && s.rx_phase == can_moh_pkg::RX_IDLE) begin
      if (RX_LIST_ERR_I) begin
        next_s.loe = 1'b1; // R3
        next_s.tx_hold = 1'b1; // R4
      end else begin
        for (int k = 0; k < can_moh_pkg::NOBJ; k++) begin
          if (!found && s.obj[k].valid && s.obj[k].rx_en && s.obj[k].id == RX_ID_I) begin
            found = 1'b1;
            i = k[can_moh_pkg::IDX_W-1:0];
          end
        end
        if (found) begin
          next_s.rx_phase = can_moh_pkg::RX_UPDATE;
          next_s.rx_idx = i;
          next_s.rx_data = RX_DATA_I;
          next_s.rx_remote = RX_REMOTE_I;
          next_s.obj[i].receive_updating_flag = 1'b1; // R19
        end
      end
    end

    // receive: storage and status update one cycle later
    if (s.rx_phase == can_moh_pkg::RX_UPDATE) begin
      i = s.rx_idx;
      next_s.rx_phase = can_moh_pkg::RX_IDLE;
      next_s.obj[i].receive_updating_flag = 1'b0; // R19
      if (!s.rx_remote) begin
        next_s.obj[i].data = s.rx_data;
        next_s.obj[i].message_lost_flag = s.obj[i].new_data_flag; // R15
        next_s.obj[i].new_data_flag = 1'b1; // R15
      end else if (!s.obj[i].frren) begin
        next_s.obj[i].txrq = 1'b1;
      end
      next_s.obj[i].receive_pending_flag = 1'b1; // R15
      next_s.rx_irq = 1'b1; // R15
      if (s.obj[i].single_transfer_mode) next_s.obj[i].valid = 1'b0; // R6
    end

    // transmit: outcome of the frame in the buffer
    if (s.tx_busy) begin
      i = s.tx_idx;
      if (TX_DONE_I) begin
        next_s.tx_busy = 1'b0;
        next_s.obj[i].txrq = 1'b0;
        if (s.obj[i].single_transfer_mode) next_s.obj[i].valid = 1'b0;
        // fifo element sent: advance current pointer inside the segment
        if (i >= s.bot && i <= s.top && i == s.cur) begin
          nc = (s.cur == s.top) ? s.bot : s.cur + 1'b1;
          next_s.cur = nc;
          if (s.ovie && nc == s.sel) next_s.ovf = 1'b1; // R1
        end
      end else if (TX_ERR_I) begin
        // destroyed frame stays in the buffer and goes again first, unless its request was withdrawn
        if (tx_withdrawn) next_s.tx_busy = 1'b0; // R7
        else next_s.tx_busy = 1'b1; // R2
      end else if (tx_withdrawn && !TX_ACTIVE_I) begin
        next_s.tx_busy = 1'b0; // R20
      end
    end else if (!s.tx_hold && !s.node_init) begin
      // transmit filtering, lowest index wins; a receive match must not leak in
      found = 1'b0;
      for (int k = 0; k < can_moh_pkg::NOBJ; k++) begin
        if (!found && s.obj[k].valid && s.obj[k].tx_en && s.obj[k].txrq) begin
          found = 1'b1;
          i = k[can_moh_pkg::IDX_W-1:0];
        end
      end
      if (found) begin
        next_s.tx_busy = 1'b1; // R2
        next_s.tx_idx = i;
        next_s.tx_frame = '{id: s.obj[i].id, data: s.obj[i].data};
        next_s.obj[i].new_data_flag = 1'b0; // R16
      end
    end
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s <= '0;
      s.node_init <= can_moh_pkg::RST_INIT;
      s.prev_rx <= 1'b1;
      s.prev_tx <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign PRDATA_O = s.prdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & s.pslverr;
  assign TX_VALID_O = s.tx_busy & ~tx_withdrawn;
  assign TX_FRAME_O = s.tx_frame;
  assign RX_IRQ_O = s.rx_irq;
  assign TX_OVERFLOW_O = s.ovf;

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  property p_ovf;
    s.tx_busy && TX_DONE_I && s.ovie && s.tx_idx == s.cur && s.cur >= s.bot
      && s.tx_idx <= s.top && ((s.cur == s.top ? s.bot : s.cur + 3'h1) == s.sel)
      |=> TX_OVERFLOW_O && s.cur == s.sel;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow pulse missing"); // R1

  property p_resend;
    s.tx_busy && TX_ERR_I && !TX_DONE_I && !tx_withdrawn
      |=> s.tx_busy && s.tx_idx == $past(s.tx_idx) && $stable(TX_FRAME_O);
  endproperty
  a_resend: assert property (p_resend) else $error("destroyed frame not kept"); // R2

  property p_loe;
    RX_FRAME_I && RX_LIST_ERR_I && !s.node_init && s.rx_phase == can_moh_pkg::RX_IDLE
      |=> s.loe && s.rx_phase == can_moh_pkg::RX_IDLE && !RX_IRQ_O ##1 !RX_IRQ_O;
  endproperty
  a_loe: assert property (p_loe) else $error("list error mishandled"); // R3

  property p_hold;
    RX_FRAME_I && RX_LIST_ERR_I && !s.node_init && s.rx_phase == can_moh_pkg::RX_IDLE
      && s.tx_busy && !TX_DONE_I && !TX_ERR_I && !tx_withdrawn |=> s.tx_busy;
  endproperty
  a_hold: assert property (p_hold) else $error("ongoing transmit disturbed"); // R4

  property p_sdt;
    s.rx_phase == can_moh_pkg::RX_UPDATE && s.obj[s.rx_idx].single_transfer_mode
      |=> !s.obj[$past(s.rx_idx)].valid;
  endproperty
  a_sdt: assert property (p_sdt) else $error("valid not cleared"); // R6

  property p_noretry;
    s.tx_busy && TX_ERR_I && !TX_DONE_I && !s.obj[s.tx_idx].valid |=> !TX_VALID_O;
  endproperty
  a_noretry: assert property (p_noretry) else $error("retry after valid cleared"); // R7

  property p_fc_rec;
    s.fc_mode == can_moh_pkg::FCMODE_TIMING && s.fc_sel == can_moh_pkg::FCSEL_REC_AFTER_DOM
      && rx_rise |=> s.fc_value == $past(s.cnt_dom) + 16'h1 || &$past(s.cnt_dom);
  endproperty
  a_fc_rec: assert property (p_fc_rec) else $error("recessive edge time wrong"); // R10

  property p_fc_loop;
    s.fc_mode == can_moh_pkg::FCMODE_TIMING && s.fc_sel == can_moh_pkg::FCSEL_TX_DOM_LOOP
      && rx_fall && !CAN_TX_I |=> s.fc_value == $past(since_txd);
  endproperty
  a_fc_loop: assert property (p_fc_loop) else $error("loop time wrong"); // R11

  property p_receive_updating_flag;
    s.rx_phase == can_moh_pkg::RX_IDLE ##1 s.rx_phase == can_moh_pkg::RX_UPDATE
      |-> s.obj[s.rx_idx].receive_updating_flag ##1 !s.obj[$past(s.rx_idx)].receive_updating_flag && RX_IRQ_O;
  endproperty
  a_receive_updating_flag: assert property (p_receive_updating_flag) else $error("update flag sequence wrong"); // R19

  property p_copy;
    !s.tx_busy ##1 s.tx_busy |-> !s.obj[s.tx_idx].new_data_flag;
  endproperty
  a_copy: assert property (p_copy) else $error("new data not cleared"); // R16

  c_tx: cover property (s.tx_busy ##[1:50] TX_DONE_I);
  c_resend: cover property (TX_ERR_I && s.tx_busy ##[1:50] TX_DONE_I);
  c_rx: cover property (s.rx_phase == can_moh_pkg::RX_UPDATE);
  c_ovf: cover property (TX_OVERFLOW_O);

endmodule

// ===== tb/can_bus_node.sv
/*
  far side of the transmit path: a bus node that carries the buffered
  frame for four cycles, then reports success or a destroyed frame.
  assumes the handler holds its valid level until done or error.
*/
module can_bus_node (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tx_valid_i,
  input wire logic hold_i,
  input wire logic fail_i,
  output logic tx_active_o,
  output logic tx_done_o,
  output logic tx_err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt;
  logic failed;
  // ************************************************
  // frame on the bus
  // ************************************************
  // with fail_i each frame is destroyed once, the resend then succeeds
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 3'h0;
      failed <= 1'b0;
      tx_active_o <= 1'b0;
      tx_done_o <= 1'b0;
      tx_err_o <= 1'b0;
    end else begin
      tx_done_o <= 1'b0;
      tx_err_o <= 1'b0;
      if (tx_active_o) begin
        cnt <= cnt + 3'h1;
        if (cnt == 3'h3) begin
          tx_active_o <= 1'b0;
          tx_err_o <= fail_i & ~failed;
          tx_done_o <= ~(fail_i & ~failed);
          failed <= fail_i & ~failed;
        end
      end else if (tx_valid_i && !hold_i && !tx_done_o && !tx_err_o) begin
        tx_active_o <= 1'b1;
        cnt <= 3'h0;
      end
    end
  end
endmodule

// ===== tb/can_message_object_handler_test.sv
/*
  self-checking bench of the message object handler: apb master tasks,
  frame pulses, bus levels and one task per scenario.
  assumes the bus node model answers the transmit buffer.
*/
module can_message_object_handler_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, psel, pen, pwr, rxf, rxr, rxl, crx, ctx, sp, sy, hold, fail;
  logic pready, pslverr, txv, txa, txd, txe, irq, ovf, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rxdat;
  logic [can_moh_pkg::ID_W-1:0] rxid;
  can_moh_pkg::tx_frame_t txf;
  logic [can_moh_pkg::ID_W-1:0] sent[$];
  int n_errors, n_compared, n_irq, n_ovf;

  can_msg_obj_handler DUT (
    .MCLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_FRAME_I(rxf),
    .RX_REMOTE_I(rxr), .RX_LIST_ERR_I(rxl), .RX_ID_I(rxid), .RX_DATA_I(rxdat),
    .TX_ACTIVE_I(txa), .TX_DONE_I(txd), .TX_ERR_I(txe), .CAN_RX_I(crx),
    .CAN_TX_I(ctx), .SAMPLE_POINT_I(sp), .SYNC_EDGE_I(sy), .TX_VALID_O(txv),
    .TX_FRAME_O(txf), .RX_IRQ_O(irq), .TX_OVERFLOW_O(ovf)
  );
  can_bus_node node (
    .clk_i(clk), .rstn_i(rstn), .tx_valid_i(txv), .hold_i(hold),
    .fail_i(fail), .tx_active_o(txa), .tx_done_o(txd), .tx_err_o(txe)
  );

  // ************************************************
  // clock and monitors
  // ************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // count output pulses and log every frame reported sent
  always @(negedge clk) begin
    if (irq === 1'b1) n_irq++;
    if (ovf === 1'b1) n_ovf++;
  end
  always @(posedge clk) begin
    if (txd === 1'b1) sent.push_back(txf.id);
  end

  // ************************************************
  // shared tasks
  // ************************************************
  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (i == 20) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  function automatic logic [11:0] oc(input int n);
    return can_moh_pkg::A_OBJ_CTRL + 12'(4 * n);
  endfunction
  task automatic rx(input logic [10:0] id, input logic [31:0] d, input logic l, input logic r);
    @(posedge clk);
    rxf <= 1'b1;
    rxid <= id;
    rxdat <= d;
    rxl <= l;
    rxr <= r;
    @(posedge clk);
    rxf <= 1'b0;
    rxl <= 1'b0;
    rxr <= 1'b0;
  endtask
  task automatic wait_sent(input int n);
    int i;
    for (i = 0; i < 100 && sent.size() < n; i++) @(posedge clk);
    if (i == 100) begin
      n_errors++;
      close_out();
    end
  endtask

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_reset();
    rdchk("node_ctrl", can_moh_pkg::A_NODE_CTRL, 32'h00000001);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    apb(1'b1, can_moh_pkg::A_NODE_CTRL, 32'h0);
  endtask
  // store while another object's valid bit is cleared
  task automatic t_rx();
    apb(1'b1, oc(0), 32'h01230013);
    apb(1'b1, oc(1), 32'h01240003);
    fork
      rx(11'h123, 32'hcafe0001, 1'b0, 1'b0);
      apb(1'b1, oc(1), 32'h01240002);
    join
    repeat (4) @(posedge clk);
    chk("rx_irq", 32'h1, 32'(n_irq));
    rdchk("obj0_ctrl", oc(0), 32'h01230152);
    rdchk("obj0_data", can_moh_pkg::A_OBJ_DATA, 32'hcafe0001);
    rdchk("obj1_ctrl", oc(1), 32'h01240002);
  endtask
  task automatic t_lerr();
    apb(1'b1, oc(2), 32'h02000003);
    rx(11'h200, 32'h1, 1'b1, 1'b0);
    repeat (6) @(posedge clk);
    chk("lerr_irq", 32'h1, 32'(n_irq));
    rdchk("node_stat", can_moh_pkg::A_NODE_STAT, 32'h1);
    rdchk("obj2_ctrl", oc(2), 32'h02000003);
    apb(1'b1, can_moh_pkg::A_NODE_STAT, 32'h1);
  endtask
  // remote frames into single transfer objects, with and without an answer request, no answer sent
  task automatic t_remote();
    apb(1'b1, can_moh_pkg::A_FIFO_CTRL, 32'h00000600);
    apb(1'b1, oc(6), 32'h03000037);
    apb(1'b1, oc(7), 32'h03010017);
    rx(11'h300, 32'h0, 1'b0, 1'b1);
    rx(11'h301, 32'h0, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    chk("remote_irq", 32'h3, 32'(n_irq));
    chk("answer_valid", 32'h0, 32'(txv));
    rdchk("obj6_ctrl", oc(6), 32'h03000136);
    rdchk("obj7_ctrl", oc(7), 32'h0301011e);
  endtask
  // each select code: two edges k cycles apart must store k
  task automatic t_meas();
    int k;
    for (int c = 1; c <= 4; c++) begin
      k = 4 + c;
      apb(1'b1, can_moh_pkg::A_NODE_CTRL, 32'(c << 3) | 32'h4);
      if (c == 3) begin
        @(posedge clk);
        ctx <= 1'b0;
        crx <= 1'b0;
        repeat (3) @(posedge clk);
      end
      @(posedge clk);
      case (c)
        1: crx <= 1'b0;
        2: ctx <= 1'b0;
        3: ctx <= 1'b1;
        default: sp <= 1'b1;
      endcase
      repeat (k) begin
        @(posedge clk);
        sp <= 1'b0;
      end
      crx <= (c == 1 || c == 3);
      sy <= (c == 4);
      repeat (3) @(posedge clk);
      rdchk("frame_count", can_moh_pkg::A_FRAME_CNT, 32'(k));
      crx <= 1'b1;
      ctx <= 1'b1;
      sy <= 1'b0;
    end
    apb(1'b1, can_moh_pkg::A_NODE_CTRL, 32'h0);
  endtask
  // priority, new data clear, withdrawal and resend after an error
  task automatic t_tx();
    hold <= 1'b1;
    fail <= 1'b1;
    apb(1'b1, oc(3), 32'h0050004d);
    apb(1'b1, oc(4), 32'h0060000d);
    repeat (4) @(posedge clk);
    rx(11'h200, 32'h1, 1'b1, 1'b0);
    chk("held_valid", 32'h1, 32'(txv));
    chk("first_id", 32'h050, 32'(txf.id));
    rdchk("obj3_ctrl", oc(3), 32'h0050000d);
    apb(1'b1, oc(3), 32'h00500005);
    repeat (4) @(posedge clk);
    chk("rerun_id", 32'h060, 32'(txf.id));
    hold <= 1'b0;
    wait_sent(1);
    repeat (20) @(posedge clk);
    chk("sent_count", 32'h1, 32'(sent.size()));
    chk("sent_id", 32'h060, 32'(sent[0]));
    rdchk("obj4_ctrl", oc(4), 32'h00600005);
  endtask
  // fifo pointer reaching the limit, with and without the enable
  task automatic t_fifo();
    fail <= 1'b0;
    apb(1'b1, can_moh_pkg::A_NODE_CTRL, 32'h00000001);
    apb(1'b1, can_moh_pkg::A_FIFO_SEG, 32'h00000605);
    apb(1'b1, can_moh_pkg::A_NODE_CTRL, 32'h0);
    for (int e = 1; e >= 0; e--) begin
      apb(1'b1, can_moh_pkg::A_FIFO_CTRL, 32'h00060500 | 32'(e));
      apb(1'b1, oc(5), 32'h0070000d);
      wait_sent(3 - e);
      repeat (4) @(posedge clk);
      chk("overflow", 32'h1, 32'(n_ovf));
      rdchk("fifo_ctrl", can_moh_pkg::A_FIFO_CTRL, 32'h00060600 | 32'(e));
    end
  endtask

  // ************************************************
  // main sequence and watchdog
  // ************************************************
  initial begin
    {rstn, psel, pen, pwr, rxf, rxr, rxl, sp, sy, hold, fail} = '0;
    {crx, ctx} = 2'b11;
    paddr = 12'h0;
    pwdata = 32'h0;
    rxid = '0;
    rxdat = 32'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_rx();
    t_lerr();
    t_remote();
    t_meas();
    t_tx();
    t_fifo();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule
